// ===== inc/usb_attach_pkg.sv
// Purpose: Shared constants and types of the USB attach/suspend/power sequencer.
// Assumes: 50 MHz system clock, a 16-bit register port on the USB peripheral.
// Notes:   Peripheral register offsets and bit positions are parameters of this file.
`default_nettype none

package usb_attach_pkg;

    // Time base
    localparam int CLK_PERIOD_NS  = 20;
    localparam int OSC_SETTLE_NS  = 1_500_000;
    localparam int PLL_LOCK_NS    = 8_300;
    localparam int CLK_OFF_NS     = 3_000;
    localparam int DEB_GAP_NS     = 1_000_000;
    // Least times, rounded up to whole cycles
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_OFF_CYC    = (CLK_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_GAP_CYC    = (DEB_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Equal level reads in a row before a level is trusted
    localparam logic [2:0] DEB_READS = 3'h4;

    // Peripheral register map
    localparam logic [7:0] DEV_XCVR_ADR   = 8'h00;
    localparam logic [7:0] DEV_INTEN_ADR  = 8'h02;
    localparam logic [7:0] DEV_INTSTS_ADR = 8'h04;
    localparam logic [7:0] DEV_WAKE_ADR   = 8'h06;
    // Transceiver control bits
    localparam int XCVR_USB_EN   = 0;
    localparam int XCVR_HS_ALLOW = 1;
    localparam int XCVR_OSC_EN   = 2;
    localparam int XCVR_REF_EN   = 3;
    localparam int XCVR_PLL_EN   = 4;
    localparam int XCVR_SYS_EN   = 5;
    localparam int XCVR_PULLUP   = 6;
    // Interrupt enable bits
    localparam int INTEN_VBUS    = 0;
    localparam int INTEN_RESUME  = 1;
    localparam int INTEN_STATE   = 2;
    // Interrupt status bits (write 0 clears, write 1 leaves)
    localparam int STS_VBUS_FLAG = 15;
    localparam int STS_RESUME    = 14;
    localparam int STS_STATE_IRQ = 12;
    localparam int STS_VBUS_LVL  = 7;
    localparam int STS_DSTATE_LO = 4;
    localparam int STS_DSTATE_HI = 6;
    localparam int WAKE_REQ_BIT  = 8;
    localparam logic [15:0] DEV_RESET_VAL = 16'h0000;
    localparam logic [15:0] STS_KEEP_ALL  = 16'hFFFF;
    localparam logic [15:0] INTEN_RUN     = 16'h0005;
    localparam logic [15:0] INTEN_SUSP    = 16'h0007;

    // Software register map (byte offsets)
    localparam logic [7:0] WB_CTRL_ADR  = 8'h00;
    localparam logic [7:0] WB_STAT_ADR  = 8'h04;
    localparam logic [7:0] WB_ISTS_ADR  = 8'h08;
    localparam logic [7:0] WB_IMSK_ADR  = 8'h0C;
    localparam int CTRL_START    = 0;
    localparam int CTRL_HS_ALLOW = 1;
    localparam int CTRL_WAKE     = 2;
    // Event bits of the interrupt status and mask registers
    localparam int EV_ATTACH  = 0;
    localparam int EV_DETACH  = 1;
    localparam int EV_SUSPEND = 2;
    localparam int EV_RESUME  = 3;
    localparam int EV_WAKE    = 4;
    localparam int EV_W       = 5;
    localparam logic [EV_W-1:0] EV_NONE = 5'h00;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  adr;
        logic [15:0] wdat;
    } dev_req_t;

    localparam dev_req_t DEV_IDLE = '{req: 1'b0, we: 1'b0, adr: 8'h00, wdat: 16'h0000};

    typedef enum logic [4:0] {
        S_IDLE     = 5'b00000, S_BUS      = 5'b00001, S_WAIT     = 5'b00010,
        S_INIT_EN  = 5'b00011, S_DEB      = 5'b00100, S_DEB_CHK  = 5'b00101,
        S_IRQ_READ = 5'b00110, S_IRQ_CHK  = 5'b00111, S_CLR_VB0  = 5'b01000,
        S_CLR_VB1  = 5'b01001, S_CLR_STATE_CHANGE_IRQ = 5'b01010, S_STATE_CHANGE_IRQ_CHK = 5'b01011,
        S_ATT_HS   = 5'b01100, S_CLK_X    = 5'b01101, S_CLK_R    = 5'b01110,
        S_CLK_P    = 5'b01111, S_CLK_S    = 5'b10000, S_ATT_RPU  = 5'b10001,
        S_DET_RPU  = 5'b10010, S_OFF_S    = 5'b10011, S_OFF_P    = 5'b10100,
        S_OFF_R    = 5'b10101, S_OFF_X    = 5'b10110, S_SUS_RESUME_IRQ_ENABLE = 5'b10111,
        S_WK_RESUME_IRQ_ENABLE  = 5'b11000, S_WK_READ  = 5'b11001, S_WK_CHK   = 5'b11010,
        S_WK_REQ   = 5'b11011, S_CLR_RESUME_FLAG = 5'b11100, S_ARM      = 5'b11101
    } seq_state_t;

    typedef enum logic [2:0] {
        G_NONE    = 3'b000, G_ATTACH = 3'b001, G_DETACH = 3'b010,
        G_SUSPEND = 3'b011, G_RESUME = 3'b100, G_WAKE   = 3'b101
    } goal_t;

endpackage

`default_nettype wire

// ===== design/usb_attach_suspend_power_ctrl.sv
// Purpose: Host-side sequencer that drives a USB peripheral through attach,
//          detach, suspend, resume and remote wakeup over its register port.
// Assumes: Peripheral port answers each request with a one-cycle ack.
// Notes:   Software orders and status go through a classic Wishbone slave.
`timescale 1ns/10ps
`default_nettype none

module usb_attach_suspend_power_ctrl
    import usb_attach_pkg::*;
#(
    parameter int OSC_WAIT_CYC = OSC_SETTLE_CYC,
    parameter int DEB_WAIT_CYC = DEB_GAP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output dev_req_t         dev_o,
    input  wire logic [15:0] dev_rdat_i,
    input  wire logic        dev_ack_i,
    input  wire logic        dev_irq_i
);

    seq_state_t      state_r;
    seq_state_t      state_nxt;
    seq_state_t      ret_r;
    goal_t           goal_r;
    goal_t           goal_nxt;
    logic [31:0]     wait_r;
    logic [31:0]     cnt_r;
    logic [15:0]     xcvr_r;
    logic [15:0]     rd_r;
    logic [2:0]      deb_cnt_r;
    logic [2:0]      deb_cnt_nxt;
    logic            deb_lvl_r;
    logic            enabled_r;
    logic            attached_r;
    logic            start_pend_r;
    logic            wake_pend_r;
    logic            hs_allow_r;
    logic [EV_W-1:0] ists_r;
    logic [EV_W-1:0] imsk_r;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ists_nxt;

    // Step table: one peripheral access per step state
    logic            st_step;
    logic            st_we;
    logic [7:0]      st_adr;
    logic [15:0]     st_dat;
    seq_state_t      st_ret;
    logic [31:0]     st_wait;

    wire        sys_on    = xcvr_r[XCVR_SYS_EN];
    wire        suspended = attached_r & ~sys_on;
    wire        rd_lvl    = rd_r[STS_VBUS_LVL];
    wire        rd_susp   = rd_r[STS_DSTATE_HI];
    wire        deb_same  = (deb_cnt_r == 3'h0) | (rd_lvl == deb_lvl_r);
    wire        deb_done  = (deb_cnt_nxt == DEB_READS);

    wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
    wire        wb_rd     = wb_req & ~wb_we_i;
    wire        wr_ctrl   = wb_wr & (wb_adr_i == WB_CTRL_ADR);
    wire        wr_imsk   = wb_wr & (wb_adr_i == WB_IMSK_ADR);
    wire        rd_ists   = wb_rd & (wb_adr_i == WB_ISTS_ADR);
    wire [31:0] stat_word = {11'h000, state_r, 5'h00, rd_r[STS_DSTATE_HI:STS_DSTATE_LO],
                             3'h0, deb_lvl_r, suspended, attached_r, enabled_r,
                             state_r != S_IDLE};
    wire [31:0] rd_mux    = (wb_adr_i == WB_CTRL_ADR) ? {30'h0000_0000, hs_allow_r, 1'b0} :
                            (wb_adr_i == WB_STAT_ADR) ? stat_word :
                            (wb_adr_i == WB_ISTS_ADR) ? {27'h000_0000, ists_r} :
                            (wb_adr_i == WB_IMSK_ADR) ? {27'h000_0000, imsk_r} :
                            32'h0000_0000;

    assign deb_cnt_nxt = deb_same ? deb_cnt_r + 3'h1 : 3'h1;

    always_comb begin
        st_step = 1'b1;
        st_we   = 1'b1;
        st_adr  = DEV_XCVR_ADR;
        st_dat  = xcvr_r;
        st_ret  = S_IDLE;
        st_wait = 32'h0000_0000;
        ev_set  = EV_NONE;
        case (state_r)
            S_INIT_EN: begin
                st_dat[XCVR_USB_EN] = 1'b1;
                st_ret = S_DEB;
            end
            S_DEB: begin
                st_we   = 1'b0;
                st_adr  = DEV_INTSTS_ADR;
                st_ret  = S_DEB_CHK;
                st_wait = 32'(DEB_WAIT_CYC);
            end
            S_IRQ_READ, S_WK_READ: begin
                st_we  = 1'b0;
                st_adr = DEV_INTSTS_ADR;
                st_ret = (state_r == S_WK_READ) ? S_WK_CHK : S_IRQ_CHK;
            end
            S_CLR_VB0: begin
                st_adr = DEV_INTSTS_ADR;
                st_dat = STS_KEEP_ALL;
                st_dat[STS_VBUS_FLAG] = 1'b0;
                st_ret = S_CLR_VB1;
            end
            S_CLR_VB1: begin
                st_adr = DEV_INTSTS_ADR;
                st_dat = STS_KEEP_ALL;
                st_ret = S_DEB;
            end
            S_CLR_STATE_CHANGE_IRQ: begin
                st_adr = DEV_INTSTS_ADR;
                st_dat = STS_KEEP_ALL;
                st_dat[STS_STATE_IRQ] = 1'b0;
                st_ret = S_STATE_CHANGE_IRQ_CHK;
            end
            S_ATT_HS: begin
                st_dat[XCVR_HS_ALLOW] = hs_allow_r;
                st_ret = S_CLK_X;
            end
            S_CLK_X: begin
                st_dat[XCVR_OSC_EN] = 1'b1;
                st_ret  = S_CLK_R;
                st_wait = 32'(OSC_WAIT_CYC);
            end
            S_CLK_R: begin
                st_dat[XCVR_REF_EN] = 1'b1;
                st_ret = S_CLK_P;
            end
            S_CLK_P: begin
                st_dat[XCVR_PLL_EN] = 1'b1;
                st_ret  = S_CLK_S;
                st_wait = 32'(PLL_LOCK_CYC);
            end
            S_CLK_S: begin
                st_dat[XCVR_SYS_EN] = 1'b1;
                st_ret = (goal_r == G_ATTACH) ? S_ATT_RPU :
                         (goal_r == G_WAKE)   ? S_WK_READ : S_CLR_RESUME_FLAG;
            end
            S_ATT_RPU: begin
                st_dat[XCVR_PULLUP] = 1'b1;
                st_ret = S_ARM;
            end
            S_DET_RPU: begin
                st_dat[XCVR_PULLUP] = 1'b0;
                st_ret = S_OFF_S;
            end
            S_OFF_S: begin
                st_dat[XCVR_SYS_EN] = 1'b0;
                st_ret  = S_OFF_P;
                st_wait = 32'(CLK_OFF_CYC);
            end
            S_OFF_P: begin
                st_dat[XCVR_PLL_EN] = 1'b0;
                st_ret  = S_OFF_R;
                st_wait = 32'(CLK_OFF_CYC);
            end
            S_OFF_R: begin
                st_dat[XCVR_REF_EN] = 1'b0;
                st_ret  = S_OFF_X;
                st_wait = 32'(CLK_OFF_CYC);
            end
            S_OFF_X: begin
                st_dat[XCVR_OSC_EN] = 1'b0;
                st_ret = (goal_r == G_SUSPEND) ? S_SUS_RESUME_IRQ_ENABLE : S_IDLE;
                ev_set[EV_DETACH] = (goal_r == G_DETACH);
            end
            S_SUS_RESUME_IRQ_ENABLE: begin
                st_adr = DEV_INTEN_ADR;
                st_dat = INTEN_SUSP;
                ev_set[EV_SUSPEND] = 1'b1;
            end
            S_WK_RESUME_IRQ_ENABLE: begin
                st_adr = DEV_INTEN_ADR;
                st_dat = INTEN_RUN;
                st_ret = S_CLK_X;
            end
            S_WK_REQ: begin
                st_adr = DEV_WAKE_ADR;
                st_dat = DEV_RESET_VAL;
                st_dat[WAKE_REQ_BIT] = 1'b1;
                st_ret = S_CLR_RESUME_FLAG;
            end
            S_CLR_RESUME_FLAG: begin
                st_adr = DEV_INTSTS_ADR;
                st_dat = STS_KEEP_ALL;
                st_dat[STS_RESUME] = 1'b0;
                st_ret = S_ARM;
            end
            S_ARM: begin
                st_adr = DEV_INTEN_ADR;
                st_dat = INTEN_RUN;
                ev_set[EV_ATTACH] = (goal_r == G_ATTACH);
                ev_set[EV_RESUME] = (goal_r == G_RESUME);
                ev_set[EV_WAKE]   = (goal_r == G_WAKE);
            end
            default: st_step = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        goal_nxt  = goal_r;
        if (st_step) begin
            state_nxt = S_BUS;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (enabled_r & dev_irq_i) begin
                        state_nxt = S_IRQ_READ;
                    end else if (wake_pend_r & suspended) begin
                        goal_nxt  = G_WAKE;
                        state_nxt = S_WK_RESUME_IRQ_ENABLE;
                    end else if (start_pend_r) begin
                        goal_nxt  = G_NONE;
                        state_nxt = S_INIT_EN;
                    end
                end
                S_BUS: begin
                    if (dev_ack_i) begin
                        state_nxt = S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (cnt_r == 32'h0000_0000) begin
                        state_nxt = ret_r;
                    end
                end
                // act only on a stable level
                S_DEB_CHK: begin
                    if (!deb_done) begin
                        state_nxt = S_DEB;
                    end else if (rd_lvl & ~attached_r) begin
                        goal_nxt  = G_ATTACH;
                        state_nxt = S_ATT_HS;
                    end else if (~rd_lvl & attached_r) begin
                        goal_nxt  = G_DETACH;
                        state_nxt = S_DET_RPU;
                    end else begin
                        goal_nxt  = G_NONE;
                        state_nxt = S_ARM;
                    end
                end
                S_IRQ_CHK: begin
                    if (rd_r[STS_VBUS_FLAG]) begin
                        state_nxt = S_CLR_VB0;
                    end else if (rd_r[STS_STATE_IRQ]) begin
                        state_nxt = S_CLR_STATE_CHANGE_IRQ;
                    end else if (rd_r[STS_RESUME]) begin
                        goal_nxt  = suspended ? G_RESUME : G_NONE;
                        state_nxt = suspended ? S_CLK_X : S_CLR_RESUME_FLAG;
                    end else begin
                        state_nxt = S_IDLE;
                    end
                end
                // gate clocks on entry to suspend
                S_STATE_CHANGE_IRQ_CHK: begin
                    if (rd_susp & attached_r & sys_on) begin
                        goal_nxt  = G_SUSPEND;
                        state_nxt = S_OFF_S;
                    end else begin
                        state_nxt = S_IDLE;
                    end
                end
                S_WK_CHK: begin
                    if (rd_r[STS_RESUME] | ~rd_susp) begin
                        state_nxt = S_CLR_RESUME_FLAG;
                    end else begin
                        state_nxt = S_WK_REQ;
                    end
                end
                default: state_nxt = S_IDLE;
            endcase
        end
    end

    // Read of the interrupt status clears it, but a new event still lands
    assign ists_nxt = (rd_ists ? EV_NONE : ists_r) | ev_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            ret_r   <= S_IDLE;
            goal_r  <= G_NONE;
            wait_r  <= 32'h0000_0000;
            cnt_r   <= 32'h0000_0000;
            dev_o   <= DEV_IDLE;
            xcvr_r  <= DEV_RESET_VAL;
            rd_r    <= DEV_RESET_VAL;
        end else begin
            state_r <= state_nxt;
            goal_r  <= goal_nxt;
            if (st_step) begin
                dev_o  <= '{req: 1'b1, we: st_we, adr: st_adr, wdat: st_dat};
                ret_r  <= st_ret;
                wait_r <= st_wait;
            end
            if (st_step & st_we & (st_adr == DEV_XCVR_ADR)) begin
                xcvr_r <= st_dat;
            end
            if (state_r == S_BUS && dev_ack_i) begin
                dev_o.req <= 1'b0;
                cnt_r     <= wait_r;
                if (!dev_o.we) begin
                    rd_r <= dev_rdat_i;
                end
            end else if (state_r == S_WAIT && cnt_r != 32'h0000_0000) begin
                cnt_r <= cnt_r - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deb_cnt_r <= 3'h0;
            deb_lvl_r <= 1'b0;
        end else if (state_r == S_DEB_CHK) begin
            deb_cnt_r <= deb_done ? 3'h0 : deb_cnt_nxt;
            deb_lvl_r <= rd_lvl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enabled_r    <= 1'b0;
            attached_r   <= 1'b0;
            start_pend_r <= 1'b0;
            wake_pend_r  <= 1'b0;
        end else begin
            if (state_r == S_INIT_EN) begin
                enabled_r <= 1'b1;
            end
            if (ev_set[EV_ATTACH]) begin
                attached_r <= 1'b1;
            end else if (ev_set[EV_DETACH]) begin
                attached_r <= 1'b0;
            end
            start_pend_r <= (wr_ctrl & wb_dat_i[CTRL_START]) |
                            (start_pend_r & (state_nxt != S_INIT_EN));
            // A wakeup asked for outside suspend has nothing to do
            wake_pend_r  <= (wr_ctrl & wb_dat_i[CTRL_WAKE]) |
                            (wake_pend_r & suspended & (goal_nxt != G_WAKE));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_allow_r <= 1'b0;
            imsk_r     <= EV_NONE;
            ists_r     <= EV_NONE;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            irq_o      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                hs_allow_r <= wb_dat_i[CTRL_HS_ALLOW];
            end
            if (wr_imsk) begin
                imsk_r <= wb_dat_i[EV_W-1:0];
            end
            ists_r   <= ists_nxt;
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_rd ? rd_mux : 32'h0000_0000;
            irq_o    <= |(ists_nxt & imsk_r);
        end
    end

endmodule

`default_nettype wire

// ===== dv/usb_dev_model.sv
// Purpose: Behavioural USB peripheral register port facing the sequencer.
// Assumes: Bench drives VBUS level, suspend and resume bus events.
// Notes:   Ack after one or three cycles; read data garbled outside ack.
`timescale 1ns/10ps
`default_nettype none
module usb_dev_model
    import usb_attach_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire dev_req_t dev_i,
    input  wire logic     slow_i,
    input  wire logic     vbus_i,
    input  wire logic     susp_i,
    input  wire logic     resume_i,
    output logic [15:0]   rdat_o,
    output logic          ack_o,
    output logic          irq_o
);
    logic [15:0] xcvr_r, inten_r, rd_r;
    logic        vflag_r, arm_r, resume_flag_r, state_change_irq_r, vbus_q, susp_q;
    logic [1:0]  dly_r;
    int          wakes;
    wire  [15:0] sts = {vflag_r, resume_flag_r, 1'b0, state_change_irq_r, 4'h0, vbus_q, susp_i, 6'h00};
    wire         go  = dev_i.req && !ack_o && (dly_r == (slow_i ? 2'h2 : 2'h0));
    wire         wr  = go && dev_i.we;
    assign rdat_o = ack_o ? rd_r : ~rd_r;
    assign irq_o  = |({vflag_r, resume_flag_r, state_change_irq_r} & {inten_r[0], inten_r[1], inten_r[2]});
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {xcvr_r, inten_r, rd_r, vflag_r, resume_flag_r, state_change_irq_r, ack_o, dly_r} <= '0;
            arm_r <= 1'b1;
            vbus_q <= vbus_i;
            susp_q <= susp_i;
            wakes <= 0;
        end else begin
            ack_o <= go;
            dly_r <= (dev_i.req && !ack_o && !go) ? dly_r + 2'h1 : 2'h0;
            vbus_q <= vbus_i;
            susp_q <= susp_i;
            if (go) rd_r <= (dev_i.adr == DEV_INTSTS_ADR) ? sts : xcvr_r;
            if (wr && dev_i.adr == DEV_XCVR_ADR) xcvr_r <= dev_i.wdat;
            if (wr && dev_i.adr == DEV_INTEN_ADR) inten_r <= dev_i.wdat;
            if (wr && dev_i.adr == DEV_INTSTS_ADR) begin
                vflag_r <= vflag_r & dev_i.wdat[STS_VBUS_FLAG];
                resume_flag_r <= resume_flag_r & dev_i.wdat[STS_RESUME];
                state_change_irq_r <= state_change_irq_r & dev_i.wdat[STS_STATE_IRQ];
                arm_r <= dev_i.wdat[STS_VBUS_FLAG] | xcvr_r[XCVR_SYS_EN];
            end
            if (wr && dev_i.adr == DEV_WAKE_ADR && dev_i.wdat[WAKE_REQ_BIT] && susp_i) wakes <= wakes + 1;
            if (vbus_i != vbus_q && arm_r) vflag_r <= 1'b1;
            if (susp_i && !susp_q) state_change_irq_r <= 1'b1;
            if (resume_i && susp_i) resume_flag_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== dv/usb_attach_suspend_power_ctrl_sva.sv
// Purpose: Port-level checks of the attach/suspend sequencer.
// Assumes: Single clock domain, synchronous reset.
// Notes:   Clock step waits judged from acked transceiver writes.
`timescale 1ns/10ps
`default_nettype none
module usb_attach_suspend_power_ctrl_sva
    import usb_attach_pkg::*;
#(
    parameter int OSC_WAIT_CYC = OSC_SETTLE_CYC
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire dev_req_t    dev_o,
    input wire logic        dev_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] last_r;
    int          osc_r, pll_r;
    wire         xw = dev_o.req && dev_o.we && dev_ack_i && dev_o.adr == DEV_XCVR_ADR;
    wire  [15:0] up = xw ? dev_o.wdat & ~last_r : 16'h0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_r <= 16'h0000;
            osc_r <= 0;
            pll_r <= 0;
        end else begin
            if (xw) last_r <= dev_o.wdat;
            osc_r <= up[XCVR_OSC_EN] ? 0 : osc_r + 1;
            pll_r <= up[XCVR_PLL_EN] ? 0 : pll_r + 1;
        end
    end
    chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat idle");
    chk_req_hold: assert property (dev_o.req && !dev_ack_i |=> dev_o.req && $stable(dev_o))
        else $error("req moved");
    chk_req_drop: assert property (dev_o.req && dev_ack_i |=> !dev_o.req) else $error("req held");
    chk_osc_settle: assert property (up[XCVR_REF_EN] |-> osc_r >= OSC_WAIT_CYC - 1)
        else $error("ref too early");
    chk_pll_lock: assert property (up[XCVR_SYS_EN] |-> pll_r >= PLL_LOCK_CYC - 1)
        else $error("sysclk too early");
    chk_clk_order: assert property (xw && dev_o.wdat[XCVR_REF_EN] |-> dev_o.wdat[XCVR_OSC_EN])
        else $error("ref without osc");
    chk_pullup_late: assert property (up[XCVR_PULLUP] |-> &dev_o.wdat[XCVR_SYS_EN:XCVR_OSC_EN])
        else $error("pullup before clocks");
    chk_pullup_first: assert property (xw && last_r[XCVR_PULLUP] && !dev_o.wdat[XCVR_PULLUP]
        |-> dev_o.wdat[XCVR_SYS_EN] == last_r[XCVR_SYS_EN]) else $error("clock with pullup");
endmodule
bind usb_attach_suspend_power_ctrl usb_attach_suspend_power_ctrl_sva
    #(.OSC_WAIT_CYC(OSC_WAIT_CYC)) chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_o(dev_o),
    .dev_ack_i(dev_ack_i));
`default_nettype wire

// ===== dv/usb_attach_suspend_power_ctrl_tb.sv
// Purpose: Self-checking bench of the attach/suspend sequencer.
// Assumes: Short oscillator and debounce waits by parameter.
// Notes:   Detach happens with clocks gated to cover re-arming.
`timescale 1ns/10ps
`default_nettype none
module usb_attach_suspend_power_ctrl_tb
    import usb_attach_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic        vbus = 1'b1, susp = 1'b0, resume = 1'b0, slow = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic        ack, irq, dack, dirq;
    logic [15:0] drdat;
    dev_req_t    dreq;
    int          miscompares = 0, n_compared = 0, cycles = 0, n;
    always #10 clk_i = ~clk_i;
    usb_attach_suspend_power_ctrl #(.OSC_WAIT_CYC(20), .DEB_WAIT_CYC(10)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .dev_o(dreq), .dev_rdat_i(drdat), .dev_ack_i(dack), .dev_irq_i(dirq));
    usb_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .dev_i(dreq), .slow_i(slow),
        .vbus_i(vbus), .susp_i(susp), .resume_i(resume), .rdat_o(drdat), .ack_o(dack),
        .irq_o(dirq));
    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        n_compared++;
        if (got !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // No own limit: only the cycle ceiling ends a hung access
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        wb(1'b0, a, 32'h0000_0000);
        chk(what, e, q);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        chk("irq_o", 32'h0000_0001, {31'h0, irq});
    endtask
    task automatic do_susp();
        susp <= 1'b0;
        @(posedge clk_i);
        susp <= 1'b1;
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0004, "suspend event");
        chk("xcvr suspended", 32'h0000_0043, {16'h0, dev.xcvr_r});
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(WB_IMSK_ADR, 32'h0000_0000, "imask reset");
        rd(8'h10, 32'h0000_0000, "unmapped");
        sel <= 4'h0;
        wb(1'b1, WB_IMSK_ADR, 32'h0000_001F);
        sel <= 4'hF;
        rd(WB_IMSK_ADR, 32'h0000_0000, "imask sel off");
        wb(1'b1, WB_IMSK_ADR, 32'h0000_001F);
        wb(1'b1, WB_CTRL_ADR, 32'h0000_0003);
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0001, "attach event");
        rd(WB_ISTS_ADR, 32'h0000_0000, "read clear");
        chk("xcvr attached", 32'h0000_007F, {16'h0, dev.xcvr_r});
        resume <= 1'b1;
        @(posedge clk_i);
        resume <= 1'b0;
        repeat (50) @(posedge clk_i);
        rd(WB_ISTS_ADR, 32'h0000_0000, "resume while active");
        do_susp();
        resume <= 1'b1;
        @(posedge clk_i);
        resume <= 1'b0;
        susp <= 1'b0;
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0008, "resume event");
        chk("xcvr resumed", 32'h0000_007F, {16'h0, dev.xcvr_r});
        do_susp();
        slow <= 1'b1;
        wb(1'b1, WB_CTRL_ADR, 32'h0000_0006);
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0010, "wakeup done");
        chk("wakeups", 32'h0000_0001, dev.wakes);
        chk("xcvr woken", 32'h0000_007F, {16'h0, dev.xcvr_r});
        do_susp();
        wb(1'b1, WB_CTRL_ADR, 32'h0000_0006);
        resume <= 1'b1;
        @(posedge clk_i);
        resume <= 1'b0;
        susp <= 1'b0;
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0010, "wake with bus awake");
        chk("wakeups kept", 32'h0000_0001, dev.wakes);
        do_susp();
        vbus <= 1'b0;
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0002, "detach event");
        repeat (2) @(posedge clk_i);
        chk("irq after read", 32'h0000_0000, {31'h0, irq});
        chk("xcvr detached", 32'h0000_0003, {16'h0, dev.xcvr_r});
        wb(1'b1, WB_IMSK_ADR, 32'h0000_0000);
        vbus <= 1'b1;
        n = 0;
        while (dev.xcvr_r !== 16'h007F && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        do begin
            wb(1'b0, WB_STAT_ADR, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        chk("masked irq", 32'h0000_0000, {31'h0, irq});
        wb(1'b1, WB_IMSK_ADR, 32'h0000_001F);
        wait_irq();
        rd(WB_ISTS_ADR, 32'h0000_0001, "reattach event");
        wrap_up();
    end
endmodule
`default_nettype wire
